/* logic/dbg_run_pkg.sv */
// Shared constants for the debug-run trigger control block
package dbg_run_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_TRIG    = 8'h04;
   localparam logic [7:0] OFS_STATE   = 8'h08;
   localparam logic [7:0] OFS_FIFO    = 8'h0c;
   localparam logic [7:0] OFS_IRQ_ST  = 8'h10;
   localparam logic [7:0] OFS_IRQ_MSK = 8'h14;
   // debug_control_reg fields
   localparam int CTRL_EN_BIT    = 7;
   localparam int CTRL_LAUNCH    = 6;
   localparam int CTRL_HALT_EN   = 5;
   localparam int CTRL_HALT_TAG  = 4;
   localparam int CTRL_A_DIR_EN  = 3;
   localparam int CTRL_A_DIR_VAL = 2;
   localparam int CTRL_B_DIR_EN  = 1;
   localparam int CTRL_B_DIR_VAL = 0;
   // debug_trigger_reg fields
   localparam int TRIG_OPC_SEL   = 7;
   localparam int TRIG_BEGIN     = 6;
   localparam int TRIG_MODE_LSB  = 0;
   localparam int TRIG_MODE_W    = 4;
   // debug_state_reg fields
   localparam int ST_A_FLAG      = 7;
   localparam int ST_B_FLAG      = 6;
   localparam int ST_RUN         = 5;
   localparam int ST_CNT_LSB     = 0;
   // Interrupt status bits
   localparam int IRQ_RUN_END    = 0;
   localparam int IRQ_A_MATCH    = 1;
   localparam int IRQ_B_MATCH    = 2;
   localparam int IRQ_W          = 3;
   // Reset values and trace FIFO width and depth
   localparam logic [7:0] CTRL_RST  = 8'h00;
   localparam logic [7:0] TRIG_RST  = 8'h00;
   localparam logic [IRQ_W-1:0] IRQ_MSK_RST = 3'h0;
   localparam int TRACE_W        = 16;
   localparam int TRACE_DEPTH    = 8;
   // Trigger modes, nine legal codes of the 4-bit field
   typedef enum logic [3:0] {
      TM_A_ONLY     = 4'h0,
      TM_A_OR_B     = 4'h1,
      TM_A_THEN_B   = 4'h2,
      TM_EVT_B      = 4'h3,
      TM_A_THEN_EVT = 4'h4,
      TM_A_AND_B    = 4'h5,
      TM_A_NOT_B    = 4'h6,
      TM_INSIDE     = 4'h7,
      TM_OUTSIDE    = 4'h8
   } trig_mode_type;
   // Run sequencer, Gray along idle -> armed -> tracing
   typedef enum logic [1:0] {
      RS_IDLE    = 2'b00,
      RS_ARMED   = 2'b01,
      RS_TRACING = 2'b11
   } run_state_type;
endpackage

/* logic/dbg_cmp_qual.sv */
// Comparator match qualification with direction check and opcode tracking
`timescale 1ns/1ps
module dbg_cmp_qual (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic rst_in,
   // Match and bus
   input  wire logic hit_in,
   input  wire logic rw_in,
   input  wire logic exec_in,
   input  wire logic flush_in,
   // Configuration
   input  wire logic dir_en_in,
   input  wire logic dir_val_in,
   input  wire logic opc_sel_in,
   // Qualified match
   output logic      qual_out
);
   logic dir_ok;
   logic raw_hit;
   logic pending_r;
   logic qual_nxt;

   assign dir_ok   = ~dir_en_in | (rw_in == dir_val_in);
   assign raw_hit  = hit_in & dir_ok;
   // Tagged fetch only counts if the opcode really executes
   assign qual_nxt = opc_sel_in ? (pending_r & exec_in) : raw_hit;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pending_r <= 1'b0;
         qual_out  <= 1'b0;
      end else begin
         qual_out <= qual_nxt;
         if (!opc_sel_in || flush_in || exec_in) begin
            pending_r <= opc_sel_in & raw_hit & ~flush_in;
         end else if (raw_hit) begin
            pending_r <= 1'b1;
         end
      end
   end
endmodule

/* logic/dbg_trace_fifo.sv */
// Trace FIFO with optional circular overwrite
`timescale 1ns/1ps
module dbg_trace_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8,
   parameter int CW    = $clog2(DEPTH + 1)
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   // Control
   input  wire logic             clr_in,
   input  wire logic             circ_in,
   // Write side
   input  wire logic             wr_in,
   input  wire logic [WIDTH-1:0] wr_data_in,
   // Read side
   input  wire logic             rd_in,
   output logic      [WIDTH-1:0] rd_data_out,
   output logic      [CW-1:0]    count_out,
   output logic                  full_out
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wp_r;
   logic [PW-1:0]    rp_r;
   logic             do_wr;
   logic             do_rd;
   logic             overwrite;

   function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
      inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign full_out    = (count_out == DEPTH_C);
   // Circular mode drops the oldest entry rather than stalling
   assign overwrite   = full_out & circ_in & wr_in;
   assign do_wr       = wr_in & (~full_out | circ_in);
   assign do_rd       = rd_in & (count_out != '0) & ~wr_in;
   assign rd_data_out = mem[rp_r];

   always_ff @(posedge clk_in) begin
      if (do_wr) begin
         mem[wp_r] <= wr_data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in || clr_in) begin
         wp_r      <= '0;
         rp_r      <= '0;
         count_out <= '0;
      end else begin
         if (do_wr) wp_r <= inc(wp_r);
         if (do_rd || overwrite) rp_r <= inc(rp_r);
         if (do_wr && !overwrite) count_out <= count_out + 1'b1;
         else if (do_rd) count_out <= count_out - 1'b1;
      end
   end
endmodule

/* logic/dbg_run_ctrl.sv */
// Debug run control, trigger qualification and trace capture
//
// Overview of operation
// - With begin select set capture starts at the qualified trigger, otherwise it is circular until it.
// - Writing 1 to the launch and module enable bits together starts a run, sets the run flag, clears both match flags and the count.
// - A begin-trace run ends as soon as the trace FIFO is full.
// - An end-trace run ends when the selected trigger event occurs.
// - Writing 0 to the launch bit or the module enable stops any run in progress.
// - Outside event-only modes the FIFO records change-of-flow addresses.
// - In event-only modes the FIFO records the data byte in the low eight bits of an entry.
// - Event-only modes ignore the begin select and always behave as begin traces.
// - A comparator with direction qualify set also needs read/write to equal its programmed value.
// - With the module and halt requests enabled the qualified match raises a tag or force breakpoint request.
// - The 4-bit trigger mode field picks one of nine trigger modes.
// - With opcode-fetch qualification a match triggers only if the tagged opcode executes.
`timescale 1ns/1ps
module dbg_run_ctrl
   import dbg_run_pkg::*;
(
   // Clock and reset
   input  wire logic                REF_CLK_IN,
   input  wire logic                RST_IN,
   // Wishbone slave
   input  wire logic                WB_CYC_IN,
   input  wire logic                WB_STB_IN,
   input  wire logic                WB_WE_IN,
   input  wire logic [7:0]          WB_ADR_IN,
   input  wire logic [3:0]          WB_SEL_IN,
   input  wire logic [31:0]         WB_DAT_IN,
   output logic      [31:0]         WB_DAT_OUT,
   output logic                     WB_ACK_OUT,
   // Core bus observation
   input  wire logic                COMP_A_HIT_IN,
   input  wire logic                COMP_B_HIT_IN,
   input  wire logic                RW_IN,
   input  wire logic                COF_VALID_IN,
   input  wire logic [15:0]         COF_ADDR_IN,
   input  wire logic [7:0]          DATA_IN,
   input  wire logic                EXEC_A_IN,
   input  wire logic                EXEC_B_IN,
   input  wire logic                QUEUE_FLUSH_IN,
   // Breakpoint requests to the core
   output logic                     BRK_REQ_OUT,
   output logic                     BRK_TAG_OUT,
   // Status
   output logic                     RUN_ACTIVE_OUT,
   output logic                     IRQ_OUT
);
   localparam int CW = $clog2(TRACE_DEPTH + 1);

   logic [7:0]          ctrl_r;
   logic [7:0]          trig_r;
   logic [IRQ_W-1:0]    irq_st_r;
   logic [IRQ_W-1:0]    irq_msk_r;
   logic                comp_a_match_flag_r;
   logic                comp_b_match_flag_r;
   logic                a_seen_r;
   run_state_type       state_r;
   run_state_type       state_nxt;
   logic [IRQ_W-1:0]    irq_st_nxt;
   logic [31:0]         rd_mux;

   // Bus decode
   logic                acc;
   logic                wr_acc;
   logic                rd_acc;
   logic                wr_ctrl;
   logic                wr_trig;
   logic                wr_msk;
   logic                rd_irq;
   logic                rd_fifo;
   logic                lane0;
   logic [7:0]          wdat;

   assign acc     = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
   assign wr_acc  = acc & WB_WE_IN;
   assign rd_acc  = acc & ~WB_WE_IN;
   assign lane0   = WB_SEL_IN[0];
   assign wdat    = WB_DAT_IN[7:0];
   assign wr_ctrl = wr_acc & lane0 & (WB_ADR_IN == OFS_CTRL);
   assign wr_trig = wr_acc & lane0 & (WB_ADR_IN == OFS_TRIG);
   assign wr_msk  = wr_acc & lane0 & (WB_ADR_IN == OFS_IRQ_MSK);
   assign rd_irq  = rd_acc & (WB_ADR_IN == OFS_IRQ_ST);
   assign rd_fifo = rd_acc & (WB_ADR_IN == OFS_FIFO);

   // Configuration views
   logic                debug_module_enable;
   logic                halt_request_enable;
   logic                opcode_qualify_select;
   logic                begin_sel;
   logic [3:0]          trigger_mode_field;
   logic                evt_only;
   logic                begin_eff;
   logic                launch_cmd;
   logic                stop_cmd;

   assign debug_module_enable   = ctrl_r[CTRL_EN_BIT];
   assign halt_request_enable   = ctrl_r[CTRL_HALT_EN];
   assign opcode_qualify_select = trig_r[TRIG_OPC_SEL];
   assign begin_sel             = trig_r[TRIG_BEGIN];
   assign trigger_mode_field    = trig_r[TRIG_MODE_LSB +: TRIG_MODE_W];
   assign evt_only   = (trigger_mode_field == TM_EVT_B) | (trigger_mode_field == TM_A_THEN_EVT);
   assign begin_eff  = begin_sel | evt_only;
   assign launch_cmd = wr_ctrl & wdat[CTRL_LAUNCH] & wdat[CTRL_EN_BIT];
   assign stop_cmd   = wr_ctrl & ~(wdat[CTRL_LAUNCH] & wdat[CTRL_EN_BIT]);

   // Comparator qualification
   logic                qual_a;
   logic                qual_b;

   dbg_cmp_qual u_qual_a (
      .clk_in     (REF_CLK_IN),
      .rst_in     (RST_IN),
      .hit_in     (COMP_A_HIT_IN),
      .rw_in      (RW_IN),
      .exec_in    (EXEC_A_IN),
      .flush_in   (QUEUE_FLUSH_IN),
      .dir_en_in  (ctrl_r[CTRL_A_DIR_EN]),
      .dir_val_in (ctrl_r[CTRL_A_DIR_VAL]),
      .opc_sel_in (opcode_qualify_select),
      .qual_out   (qual_a)
   );

   dbg_cmp_qual u_qual_b (
      .clk_in     (REF_CLK_IN),
      .rst_in     (RST_IN),
      .hit_in     (COMP_B_HIT_IN),
      .rw_in      (RW_IN),
      .exec_in    (EXEC_B_IN),
      .flush_in   (QUEUE_FLUSH_IN),
      .dir_en_in  (ctrl_r[CTRL_B_DIR_EN]),
      .dir_val_in (ctrl_r[CTRL_B_DIR_VAL]),
      .opc_sel_in (opcode_qualify_select),
      .qual_out   (qual_b)
   );

   // Trigger selection over the nine modes
   logic                trig_hit;
   logic                evt_store;
   logic                running;

   assign running = (state_r != RS_IDLE);
   always_comb begin
      trig_hit = 1'b0;
      unique case (trigger_mode_field)
         TM_A_ONLY:     trig_hit = qual_a;
         TM_A_OR_B:     trig_hit = qual_a | qual_b;
         TM_A_THEN_B:   trig_hit = a_seen_r & qual_b;
         TM_EVT_B:      trig_hit = qual_b;
         TM_A_THEN_EVT: trig_hit = a_seen_r & qual_b;
         TM_A_AND_B:    trig_hit = qual_a & qual_b;
         TM_A_NOT_B:    trig_hit = qual_a & ~qual_b;
         TM_INSIDE:     trig_hit = qual_a & qual_b;
         TM_OUTSIDE:    trig_hit = (qual_a | qual_b) & ~(qual_a & qual_b);
         default:       trig_hit = 1'b0;
      endcase
   end
   // Event modes store one byte per qualified event
   assign evt_store = evt_only & (state_r == RS_TRACING) & trig_hit;

   // Trace capture
   logic                fifo_wr;
   logic [15:0]         fifo_wdata;
   logic [15:0]         fifo_rdata;
   logic [CW-1:0]       fifo_fill_count;
   logic                fifo_full;
   logic                cof_store;

   assign cof_store  = ~evt_only & COF_VALID_IN &
                       ((state_r == RS_TRACING) | ((state_r == RS_ARMED) & ~begin_eff));
   assign fifo_wr    = cof_store | evt_store;
   assign fifo_wdata = evt_only ? {8'h00, DATA_IN} : COF_ADDR_IN;

   dbg_trace_fifo #(
      .WIDTH (TRACE_W),
      .DEPTH (TRACE_DEPTH),
      .CW    (CW)
   ) u_fifo (
      .clk_in      (REF_CLK_IN),
      .rst_in      (RST_IN),
      .clr_in      (launch_cmd),
      .circ_in     (~begin_eff),
      .wr_in       (fifo_wr),
      .wr_data_in  (fifo_wdata),
      .rd_in       (rd_fifo & ~running),
      .rd_data_out (fifo_rdata),
      .count_out   (fifo_fill_count),
      .full_out    (fifo_full)
   );

   // Run sequencer
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         RS_IDLE:
            if (launch_cmd) state_nxt = begin_eff & ~evt_only ? RS_ARMED :
                                        evt_only ? RS_TRACING : RS_ARMED;
         RS_ARMED:
            if (trig_hit) state_nxt = begin_eff ? RS_TRACING : RS_IDLE;
         RS_TRACING:
            if (fifo_full) state_nxt = RS_IDLE;
         default:
            state_nxt = RS_IDLE;
      endcase
      if (stop_cmd || !debug_module_enable) state_nxt = RS_IDLE;
      if (launch_cmd) state_nxt = evt_only ? RS_TRACING : RS_ARMED;
   end

   // Interrupt events; set wins over the read clear
   logic                run_end_evt;
   assign run_end_evt = running & (state_nxt == RS_IDLE) & ~launch_cmd;
   assign irq_st_nxt  = (rd_irq ? '0 : irq_st_r) |
                        {running & qual_b, running & qual_a, run_end_evt};

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (WB_ADR_IN)
         OFS_CTRL:    rd_mux = {24'h00_0000, ctrl_r[7], RUN_ACTIVE_OUT, ctrl_r[5:0]};
         OFS_TRIG:    rd_mux = {24'h00_0000, trig_r};
         OFS_STATE:   rd_mux = {24'h00_0000, comp_a_match_flag_r, comp_b_match_flag_r,
                                RUN_ACTIVE_OUT, 5'(fifo_fill_count)};
         OFS_FIFO:    rd_mux = {16'h0000, fifo_rdata};
         OFS_IRQ_ST:  rd_mux = {29'h0000_0000, irq_st_r};
         OFS_IRQ_MSK: rd_mux = {29'h0000_0000, irq_msk_r};
         default:     rd_mux = 32'h0000_0000;
      endcase
   end

   // Bus slave: ack one cycle after the request, unmapped reads give zero
   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         WB_ACK_OUT <= 1'b0;
         WB_DAT_OUT <= 32'h0000_0000;
      end else begin
         WB_ACK_OUT <= acc;
         if (rd_acc) WB_DAT_OUT <= rd_mux;
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         ctrl_r    <= CTRL_RST;
         trig_r    <= TRIG_RST;
         irq_msk_r <= IRQ_MSK_RST;
         irq_st_r  <= '0;
         IRQ_OUT   <= 1'b0;
      end else begin
         if (wr_ctrl) ctrl_r <= wdat;
         if (wr_trig) trig_r <= wdat;
         if (wr_msk)  irq_msk_r <= wdat[IRQ_W-1:0];
         irq_st_r <= irq_st_nxt;
         IRQ_OUT  <= |(irq_st_nxt & irq_msk_r);
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         state_r             <= RS_IDLE;
         RUN_ACTIVE_OUT      <= 1'b0;
         a_seen_r            <= 1'b0;
         comp_a_match_flag_r <= 1'b0;
         comp_b_match_flag_r <= 1'b0;
      end else begin
         state_r        <= state_nxt;
         RUN_ACTIVE_OUT <= (state_nxt != RS_IDLE);
         if (launch_cmd) begin
            a_seen_r            <= 1'b0;
            comp_a_match_flag_r <= 1'b0;
            comp_b_match_flag_r <= 1'b0;
         end else if (running) begin
            a_seen_r            <= a_seen_r | qual_a;
            comp_a_match_flag_r <= comp_a_match_flag_r | qual_a;
            comp_b_match_flag_r <= comp_b_match_flag_r | qual_b;
         end
      end
   end

   // Breakpoint request from qualified comparators; the core handles tag vs force
   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         BRK_REQ_OUT <= 1'b0;
         BRK_TAG_OUT <= 1'b0;
      end else begin
         BRK_REQ_OUT <= debug_module_enable & halt_request_enable & (qual_a | qual_b);
         BRK_TAG_OUT <= ctrl_r[CTRL_HALT_TAG];
      end
   end

   // Checks
   property p_launch_starts;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
         launch_cmd |=> RUN_ACTIVE_OUT && !comp_a_match_flag_r && fifo_fill_count == '0;
   endproperty
   a_launch_starts: assert property (p_launch_starts) else $error("launch did not start run");

   property p_stop;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
         stop_cmd |=> !RUN_ACTIVE_OUT;
   endproperty
   a_stop: assert property (p_stop) else $error("manual stop ignored");

   property p_full_ends;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
         (state_r == RS_TRACING && fifo_full && !launch_cmd) |=> state_r == RS_IDLE;
   endproperty
   a_full_ends: assert property (p_full_ends) else $error("full fifo did not end run");

   property p_end_trig;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
         (state_r == RS_ARMED && !begin_eff && trig_hit && !wr_ctrl) |=> !RUN_ACTIVE_OUT;
   endproperty
   a_end_trig: assert property (p_end_trig) else $error("end trace did not stop on trigger");

   property p_begin_wait;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
         (state_r == RS_ARMED && begin_eff) |-> !fifo_wr;
   endproperty
   a_begin_wait: assert property (p_begin_wait) else $error("begin trace stored before trigger");

   property p_evt_data;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
         (fifo_wr && evt_only) |-> trig_hit && state_r == RS_TRACING && fifo_wdata == {8'h00, DATA_IN};
   endproperty
   a_evt_data: assert property (p_evt_data) else $error("event entry not a data byte");

   property p_evt_begin;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
         (launch_cmd && evt_only) |=> state_r == RS_TRACING;
   endproperty
   a_evt_begin: assert property (p_evt_begin) else $error("event mode not begin type");

   property p_brk;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
         (qual_a && debug_module_enable && halt_request_enable) |=> BRK_REQ_OUT;
   endproperty
   a_brk: assert property (p_brk) else $error("missing breakpoint request");

   property p_run_flag;
      @(posedge REF_CLK_IN) disable iff (RST_IN)
         $fell(RUN_ACTIVE_OUT) |-> $past(fifo_full || trig_hit || wr_ctrl);
   endproperty
   a_run_flag: assert property (p_run_flag) else $error("run flag out of step with state");
endmodule

/* testbench/core_brk_model.sv */
// Core model that takes breakpoint requests and enters background mode
`timescale 1ns/1ps
module core_brk_model (
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   // Breakpoint requests
   input  wire logic       brk_req_in,
   input  wire logic       brk_tag_in,
   // Background entries taken
   output logic [7:0]      enter_background_opcode_cnt_out,
   output logic            last_tag_out
);
   logic force_pend_r;

   // Force waits one cycle for the current instruction to finish
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         enter_background_opcode_cnt_out <= 8'h00;
         last_tag_out <= 1'b0;
         force_pend_r <= 1'b0;
      end else begin
         force_pend_r <= brk_req_in & ~brk_tag_in;
         if (brk_req_in && brk_tag_in) begin
            enter_background_opcode_cnt_out <= enter_background_opcode_cnt_out + 8'h01;
            last_tag_out <= 1'b1;
         end else if (force_pend_r) begin
            enter_background_opcode_cnt_out <= enter_background_opcode_cnt_out + 8'h01;
            last_tag_out <= 1'b0;
         end
      end
   end
endmodule

/* testbench/tb_dbg_run_ctrl.sv */
// Register-level bench for the debug run control block
`timescale 1ns/1ps
module tb_dbg_run_ctrl;
   import dbg_run_pkg::*;
   logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ha = 0, hb = 0, rw = 0;
   logic        cofv = 0, ea = 0, eb = 0, fl = 0, ack, brk, tag, run, irq, ltag;
   logic [7:0]  adr = 8'h00, dat8 = 8'h00, bcnt;
   logic [15:0] cofa = 16'h0000;
   logic [31:0] wdat = 32'h0, rdat;
   int          err_count = 0, checks_done = 0, cycles = 0;
   logic [9:0]  ends = 10'h147;

   dbg_run_ctrl dut_u (.REF_CLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
      .WB_ADR_IN(adr), .WB_SEL_IN(4'hf), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
      .COMP_A_HIT_IN(ha), .COMP_B_HIT_IN(hb), .RW_IN(rw), .COF_VALID_IN(cofv), .COF_ADDR_IN(cofa),
      .DATA_IN(dat8), .EXEC_A_IN(ea), .EXEC_B_IN(eb), .QUEUE_FLUSH_IN(fl), .BRK_REQ_OUT(brk),
      .BRK_TAG_OUT(tag), .RUN_ACTIVE_OUT(run), .IRQ_OUT(irq));
   core_brk_model core_u (.clk_in(clk), .rst_in(rst), .brk_req_in(brk), .brk_tag_in(tag),
      .enter_background_opcode_cnt_out(bcnt), .last_tag_out(ltag));

   initial begin
      forever #5 clk = ~clk;
   end

   task automatic wrap_up;
      if (err_count == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // Generous ceiling, the sequence needs well under two thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         wrap_up();
      end
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      wb(1'b1, a, {24'h0, d}, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk($sformatf("reg %h", a), e, q);
   endtask

   task automatic idle;
      repeat (4) @(posedge clk);
   endtask

   // Data byte held until the next call, past the qualified event
   task automatic hit(input logic a, input logic b, input logic [7:0] d);
      @(posedge clk);
      ha <= a; hb <= b; dat8 <= d;
      @(posedge clk);
      ha <= 1'b0; hb <= 1'b0;
   endtask

   task automatic cof(input logic [15:0] ad);
      @(posedge clk);
      cofv <= 1'b1; cofa <= ad;
      @(posedge clk);
      cofv <= 1'b0;
   endtask

   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(OFS_CTRL, 32'h0); rd(OFS_TRIG, 32'h0); rd(OFS_STATE, 32'h0); rd(8'h1c, 32'h0);
      wr(OFS_TRIG, 8'h40); wr(OFS_CTRL, 8'hc0);
      chk("run", 1, run);
      rd(OFS_STATE, 32'h20);
      cof(16'h0bad); cof(16'h0bad);
      rd(OFS_STATE, 32'h20);
      hit(1, 0, 8'h00);
      for (int i = 0; i < 8; i++) cof(16'h1000 + i[15:0]);
      idle();
      rd(OFS_STATE, 32'h88);
      rd(OFS_FIFO, 32'h1000);
      wr(OFS_TRIG, 8'h00); wr(OFS_CTRL, 8'hc0);
      for (int i = 0; i < 10; i++) cof(16'h2000 + i[15:0]);
      rd(OFS_STATE, 32'h28);
      hit(1, 0, 8'h00);
      idle();
      rd(OFS_STATE, 32'h88);
      rd(OFS_FIFO, 32'h2002);
      chk("irq masked", 0, irq);
      wr(OFS_IRQ_MSK, 8'h01);
      idle();
      chk("irq", 1, irq);
      rd(OFS_IRQ_ST, 32'h3);
      idle();
      chk("irq cleared", 0, irq);
      rd(OFS_IRQ_ST, 32'h0);
      wr(OFS_CTRL, 8'hc0); wr(OFS_CTRL, 8'h80);
      chk("run", 0, run);
      wr(OFS_CTRL, 8'hc0); wr(OFS_CTRL, 8'h40);
      chk("run", 0, run);
      wr(OFS_TRIG, 8'h03); wr(OFS_CTRL, 8'hc0);
      for (int i = 0; i < 8; i++) hit(0, 1, 8'ha0 + i[7:0]);
      idle();
      rd(OFS_STATE, 32'h48);
      rd(OFS_FIFO, 32'ha0);
      for (int m = 0; m < 10; m++) begin
         wr(OFS_TRIG, m[7:0]); wr(OFS_CTRL, 8'hc0);
         hit(1, 0, 8'h00); hit(0, 1, 8'h00);
         idle();
         chk($sformatf("run mode %0d", m), {31'h0, ~ends[m]}, {31'h0, run});
      end
      wr(OFS_TRIG, 8'h0f); wr(OFS_CTRL, 8'hac);
      rw <= 1'b0;
      hit(1, 0, 8'h00); idle();
      chk("brk count", 0, {24'h0, bcnt});
      rw <= 1'b1;
      hit(1, 0, 8'h00); idle();
      chk("brk count", 1, {24'h0, bcnt});
      chk("brk kind", 0, ltag);
      wr(OFS_CTRL, 8'hbc);
      hit(1, 0, 8'h00); idle();
      chk("brk count", 2, {24'h0, bcnt});
      chk("brk kind", 1, ltag);
      wr(OFS_CTRL, 8'ha3);
      rw <= 1'b0;
      hit(0, 1, 8'h00); idle();
      chk("brk count", 2, {24'h0, bcnt});
      rw <= 1'b1;
      hit(0, 1, 8'h00); idle();
      chk("brk count", 3, {24'h0, bcnt});
      // Opcode fetches are reads, so no direction qualify here
      wr(OFS_TRIG, 8'h8f); wr(OFS_CTRL, 8'ha0);
      hit(1, 0, 8'h00); idle();
      chk("brk count", 3, {24'h0, bcnt});
      @(posedge clk);
      ea <= 1'b1;
      @(posedge clk);
      ea <= 1'b0;
      idle();
      chk("brk count", 4, {24'h0, bcnt});
      // Flushed tag must not fire when the opcode later executes
      hit(1, 0, 8'h00);
      @(posedge clk);
      fl <= 1'b1;
      @(posedge clk);
      fl <= 1'b0;
      ea <= 1'b1;
      @(posedge clk);
      ea <= 1'b0;
      idle();
      chk("brk count", 4, {24'h0, bcnt});
      wrap_up();
   end
endmodule
